/* File: inc/core_alu_pkg.sv */
/*
  Constants shared by the branch condition and adder block: register offsets,
  field positions, reset values, bus answers and the jump test encodings.
  Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
*/
package core_alu_pkg;

  // ************************************************************
  // Bus and register map.
  // ************************************************************
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] OFF_DST     = 8'h00;
  localparam logic [7:0] OFF_SRC     = 8'h04;
  localparam logic [7:0] OFF_FLAGS   = 8'h08;
  localparam logic [7:0] OFF_CMD     = 8'h0c;
  localparam logic [7:0] OFF_PC      = 8'h10;
  localparam logic [7:0] OFF_TARGET  = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int FLAG_COUNT     = 6;
  localparam int FLAG_C         = 0;
  localparam int FLAG_Z         = 1;
  localparam int FLAG_S         = 2;
  localparam int FLAG_V         = 3;
  localparam int FLAG_D         = 4;
  localparam int FLAG_H         = 5;
  localparam int CMD_ADD_BIT    = 0;
  localparam int CMD_CARRY_BIT  = 1;
  localparam int CMD_JUMP_BIT   = 2;
  localparam int CMD_TEST_LSB   = 4;
  localparam int TEST_W         = 4;
  localparam int STAT_TAKEN_BIT = 0;
  localparam int STAT_TEST_LSB  = 4;
  localparam int HALF_BIT       = 4;

  // ************************************************************
  // Values after reset.
  // ************************************************************
  localparam logic [7:0]  RST_OPERAND = 8'h00;
  localparam logic [5:0]  RST_FLAGS   = 6'h00;
  localparam logic [15:0] RST_PC      = 16'h0000;
  localparam logic [3:0]  RST_TEST    = 4'h0;

  // ************************************************************
  // Jump test encodings.
  // ************************************************************
  typedef enum logic [3:0] {
    NEVER_TAKEN        = 4'h0,
    SIGNED_BELOW       = 4'h1,
    SIGNED_AT_MOST     = 4'h2,
    UNSIGNED_AT_MOST   = 4'h3,
    SIGNED_ERR_TEST    = 4'h4,
    NEGATIVE_TEST      = 4'h5,
    OPERANDS_SAME      = 4'h6,
    UNSIGNED_BELOW     = 4'h7,
    ALWAYS_TAKEN       = 4'h8,
    SIGNED_AT_LEAST    = 4'h9,
    SIGNED_ABOVE       = 4'ha,
    UNSIGNED_ABOVE     = 4'hb,
    NO_SIGNED_ERR_TEST = 4'hc,
    POSITIVE_TEST      = 4'hd,
    NONNULL_TEST       = 4'he,
    UNSIGNED_AT_LEAST  = 4'hf
  } jump_test_t;

  localparam jump_test_t OPERANDS_DIFFER = NONNULL_TEST;
  localparam jump_test_t CARRY_SET_TEST  = UNSIGNED_BELOW;
  localparam jump_test_t CARRY_CLR_TEST  = UNSIGNED_AT_LEAST;

endpackage

/* File: design/jump_test_eval.sv */
/*
  Combinational evaluation of a 4-bit jump test against the four status flags.
  Assumes the flags come from registers on the same clock as the caller.
*/
`timescale 1ns/1ps
`default_nettype none

module jump_test_eval (
  input  wire logic [3:0] testField,
  input  wire logic       carry,
  input  wire logic       zero,
  input  wire logic       sign,
  input  wire logic       overflow,
  output logic            taken
);

  // ************************************************************
  // Base conditions, indexed by the low three bits of the test.
  // ************************************************************
  logic       signedLess;
  logic       signedAtMost;
  logic       unsignedAtMost;
  logic [7:0] baseTest;

  assign signedLess     = sign ^ overflow;
  assign signedAtMost   = zero | signedLess;
  assign unsignedAtMost = carry | zero;

  // Index 0 never holds and index 7 is the carry, which also serves unsigned below.
  assign baseTest = {carry, zero, sign, overflow,
                     unsignedAtMost, signedAtMost, signedLess, 1'b0};

  // The top bit of the test inverts the base condition.
  assign taken = baseTest[testField[2:0]] ^ testField[3];

endmodule

`default_nettype wire

/* File: design/branch_condition_and_adder.sv */
/*
  Branch condition evaluator and 8-bit adder with flag update, reached as an
  AXI4-Lite slave. Assumes one clock, a synchronous active-high reset, and a
  master that keeps to the AXI4-Lite handshake rules.
*/
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
// What this block does
// - Each conditional jump carries a 4-bit test field choosing its condition.
// - Test 0000 never branches; test 1000 always branches.
// - Single-flag tests on carry, sign and overflow, set or clear.
// - Test 0110 is zero set, 1110 zero clear; equality tests share them.
// - Signed at least when sign XOR overflow is 0; below when 1.
// - Signed above when zero OR (sign XOR overflow) is 0; at most when 1.
// - Unsigned at least reuses 1111; unsigned below reuses 0111.
// - Unsigned above needs carry and zero clear; at most when either set.
// - Add with carry stores destination plus source plus carry flag.
// - Plain add stores destination plus source; source stays unchanged.
// - Both adds are two's complement binary additions.
// - Carry-in lets software chain multi-byte additions.
// - Carry flag follows the carry out of the top result bit.
// - Zero flag set when the stored result is zero.
// - Sign flag copies the result's top bit.
// - Overflow set when operands share a sign the result lacks.
// - Half-carry follows the carry out of bit 3.
`timescale 1ns/1ps
`default_nettype none

module branch_condition_and_adder #(
  parameter int DATA_W   = 8,
  parameter int PC_W     = 16,
  parameter int JUMP_LEN = 3
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic             bvalid,
  output logic [1:0]       bresp,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  // ************************************************************
  // Parameter checks.
  // ************************************************************
  if (DATA_W < 5 || DATA_W > 8) begin : g_bad_data
    $error("DATA_W must lie between 5 and 8.");
  end
  if (PC_W < 9 || PC_W > 16) begin : g_bad_pc
    $error("PC_W must lie between 9 and 16.");
  end
  if (JUMP_LEN < 1 || JUMP_LEN > 7) begin : g_bad_len
    $error("JUMP_LEN must lie between 1 and 7.");
  end

  localparam int MSB = DATA_W - 1;

  // ************************************************************
  // State.
  // ************************************************************
  logic [DATA_W-1:0] dst;
  logic [DATA_W-1:0] src;
  logic [5:0]        flags;
  logic [PC_W-1:0]   pc;
  logic [PC_W-1:0]   target;
  logic              lastTaken;
  logic [3:0]        lastTest;
  logic              awHeld;
  logic [7:0]        awAddrQ;
  logic              wHeld;
  logic [31:0]       wDataQ;
  logic [3:0]        wStrbQ;

  // ************************************************************
  // Write channel decode.
  // ************************************************************
  logic        awTake;
  logic        wTake;
  logic        awHas;
  logic        wHas;
  logic        doWrite;
  logic [7:0]  wrAddr;
  logic [7:0]  wrWord;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic        hitDst;
  logic        hitSrc;
  logic        hitFlags;
  logic        hitCmd;
  logic        hitPc;
  logic        hitTarget;
  logic        hitStatus;
  logic        wrKnown;

  assign awready   = ~awHeld & ~bvalid;
  assign wready    = ~wHeld & ~bvalid;
  assign awTake    = awvalid & awready;
  assign wTake     = wvalid & wready;
  assign awHas     = awHeld | awTake;
  assign wHas      = wHeld | wTake;
  assign doWrite   = awHas & wHas & ~bvalid;
  assign wrAddr    = awHeld ? awAddrQ : awaddr;
  assign wrData    = wHeld ? wDataQ : wdata;
  assign wrStrb    = wHeld ? wStrbQ : wstrb;
  assign wrWord    = {wrAddr[7:2], 2'b00};
  assign hitDst    = doWrite && (wrWord == core_alu_pkg::OFF_DST);
  assign hitSrc    = doWrite && (wrWord == core_alu_pkg::OFF_SRC);
  assign hitFlags  = doWrite && (wrWord == core_alu_pkg::OFF_FLAGS);
  assign hitCmd    = doWrite && (wrWord == core_alu_pkg::OFF_CMD);
  assign hitPc     = doWrite && (wrWord == core_alu_pkg::OFF_PC);
  assign hitTarget = doWrite && (wrWord == core_alu_pkg::OFF_TARGET);
  assign hitStatus = doWrite && (wrWord == core_alu_pkg::OFF_STATUS);
  assign wrKnown   = hitDst | hitSrc | hitFlags | hitCmd | hitPc | hitTarget | hitStatus;

  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    mergeLanes = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // ************************************************************
  // Commands.
  // ************************************************************
  logic       addGo;
  logic       withCarry;
  logic       jumpGo;
  logic [3:0] testField;

  assign addGo     = hitCmd & wrStrb[0] & wrData[core_alu_pkg::CMD_ADD_BIT];
  assign withCarry = wrData[core_alu_pkg::CMD_CARRY_BIT];
  assign jumpGo    = hitCmd & wrStrb[0] & wrData[core_alu_pkg::CMD_JUMP_BIT];
  assign testField = wrData[core_alu_pkg::CMD_TEST_LSB +: core_alu_pkg::TEST_W];

  // ************************************************************
  // Adder and flag results.
  // ************************************************************
  logic              flagC;
  logic              flagZ;
  logic              flagS;
  logic              flagV;
  logic              flagD;
  logic              flagH;
  logic              carryIn;
  logic [DATA_W:0]   fullSum;
  logic [4:0]        nibbleSum;
  logic [DATA_W-1:0] sumOut;
  logic              dstMsb;
  logic              srcMsb;
  logic              dstBit4;
  logic              srcBit4;
  logic [5:0]        addFlags;

  assign flagC   = flags[core_alu_pkg::FLAG_C];
  assign flagZ   = flags[core_alu_pkg::FLAG_Z];
  assign flagS   = flags[core_alu_pkg::FLAG_S];
  assign flagV   = flags[core_alu_pkg::FLAG_V];
  assign flagD   = flags[core_alu_pkg::FLAG_D];
  assign flagH   = flags[core_alu_pkg::FLAG_H];
  assign dstMsb  = dst[MSB];
  assign srcMsb  = src[MSB];
  assign dstBit4 = dst[core_alu_pkg::HALF_BIT];
  assign srcBit4 = src[core_alu_pkg::HALF_BIT];

  assign carryIn   = withCarry & flagC;
  assign fullSum   = {1'b0, dst} + {1'b0, src} + {{DATA_W{1'b0}}, carryIn};
  assign nibbleSum = {1'b0, dst[3:0]} + {1'b0, src[3:0]} + {4'h0, carryIn};
  assign sumOut    = fullSum[DATA_W-1:0];

  assign addFlags[core_alu_pkg::FLAG_C] = fullSum[DATA_W];
  assign addFlags[core_alu_pkg::FLAG_Z] = (sumOut == '0);
  assign addFlags[core_alu_pkg::FLAG_S] = sumOut[MSB];
  assign addFlags[core_alu_pkg::FLAG_V] = (dstMsb == srcMsb) && (sumOut[MSB] != dstMsb);
  assign addFlags[core_alu_pkg::FLAG_D] = 1'b0;
  assign addFlags[core_alu_pkg::FLAG_H] = nibbleSum[4];

  // ************************************************************
  // Jump test and program counter.
  // ************************************************************
  logic            testTrue;
  logic [PC_W-1:0] nextSeq;

  jump_test_eval u_eval (
    .testField (testField),
    .carry     (flagC),
    .zero      (flagZ),
    .sign      (flagS),
    .overflow  (flagV),
    .taken     (testTrue)
  );

  assign nextSeq = pc + PC_W'(JUMP_LEN);

  // ************************************************************
  // Next register values.
  // ************************************************************
  logic [DATA_W-1:0] next_dst;
  logic [DATA_W-1:0] next_src;
  logic [5:0]        next_flags;
  logic [PC_W-1:0]   next_pc;
  logic [PC_W-1:0]   next_target;
  logic              next_lastTaken;
  logic [3:0]        next_lastTest;

  assign next_dst    = (hitDst & wrStrb[0]) ? wrData[DATA_W-1:0] :
                       addGo ? sumOut : dst;
  assign next_src    = (hitSrc & wrStrb[0]) ? wrData[DATA_W-1:0] : src;
  assign next_flags  = (hitFlags & wrStrb[0]) ? wrData[5:0] :
                       addGo ? addFlags : flags;
  assign next_pc     = hitPc ? PC_W'(mergeLanes(16'(pc), wrData, wrStrb)) :
                       jumpGo ? (testTrue ? target : nextSeq) : pc;
  assign next_target = hitTarget ? PC_W'(mergeLanes(16'(target), wrData, wrStrb)) : target;
  assign next_lastTaken = jumpGo ? testTrue : lastTaken;
  assign next_lastTest  = jumpGo ? testField : lastTest;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dst       <= core_alu_pkg::RST_OPERAND[DATA_W-1:0];
      src       <= core_alu_pkg::RST_OPERAND[DATA_W-1:0];
      flags     <= core_alu_pkg::RST_FLAGS;
      pc        <= core_alu_pkg::RST_PC[PC_W-1:0];
      target    <= core_alu_pkg::RST_PC[PC_W-1:0];
      lastTaken <= 1'b0;
      lastTest  <= core_alu_pkg::RST_TEST;
    end else begin
      dst       <= next_dst;
      src       <= next_src;
      flags     <= next_flags;
      pc        <= next_pc;
      target    <= next_target;
      lastTaken <= next_lastTaken;
      lastTest  <= next_lastTest;
    end
  end

  // ************************************************************
  // Write channel holding and response.
  // ************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awHeld  <= 1'b0;
      awAddrQ <= 8'h00;
      wHeld   <= 1'b0;
      wDataQ  <= 32'h0000_0000;
      wStrbQ  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= core_alu_pkg::RESP_OKAY;
    end else begin
      awHeld <= awHas & ~doWrite;
      wHeld  <= wHas & ~doWrite;
      if (awTake) begin
        awAddrQ <= awaddr;
      end
      if (wTake) begin
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= wrKnown ? core_alu_pkg::RESP_OKAY : core_alu_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Read channel.
  // ************************************************************
  logic        arTake;
  logic [7:0]  rdWord;
  logic        rdKnown;
  logic [31:0] rdValue;

  assign arready = ~rvalid;
  assign arTake  = arvalid & arready;
  assign rdWord  = {araddr[7:2], 2'b00};
  assign rdKnown = (rdWord == core_alu_pkg::OFF_DST) || (rdWord == core_alu_pkg::OFF_SRC) ||
                   (rdWord == core_alu_pkg::OFF_FLAGS) || (rdWord == core_alu_pkg::OFF_CMD) ||
                   (rdWord == core_alu_pkg::OFF_PC) || (rdWord == core_alu_pkg::OFF_TARGET) ||
                   (rdWord == core_alu_pkg::OFF_STATUS);
  assign rdValue = (rdWord == core_alu_pkg::OFF_DST)    ? 32'(dst) :
                   (rdWord == core_alu_pkg::OFF_SRC)    ? 32'(src) :
                   (rdWord == core_alu_pkg::OFF_FLAGS)  ? 32'(flags) :
                   (rdWord == core_alu_pkg::OFF_PC)     ? 32'(pc) :
                   (rdWord == core_alu_pkg::OFF_TARGET) ? 32'(target) :
                   (rdWord == core_alu_pkg::OFF_STATUS) ?
                     32'({lastTest, 3'h0, lastTaken}) : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= core_alu_pkg::RESP_OKAY;
    end else if (arTake) begin
      rvalid <= 1'b1;
      rdata  <= rdValue;
      rresp  <= rdKnown ? core_alu_pkg::RESP_OKAY : core_alu_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_jump_with(logic [3:0] code);
    jumpGo && (testField == code);
  endsequence

  sequence s_write_taken;
    doWrite;
  endsequence

  sequence s_resp_waiting;
    bvalid && !bready;
  endsequence

  a_never_taken: assert property (s_jump_with(core_alu_pkg::NEVER_TAKEN) |=>
    pc == $past(nextSeq)) else $error("Never-taken test moved pc to the target.");
  a_always_taken: assert property (s_jump_with(core_alu_pkg::ALWAYS_TAKEN) |=>
    pc == $past(target)) else $error("Always-taken test did not load the target.");
  a_carry_tests: assert property (jumpGo && (testField[2:0] == 3'h7) |=>
    lastTaken == ($past(flagC) ^ $past(testField[3]))) else $error("Carry test wrong.");
  a_zero_tests: assert property (jumpGo && (testField[2:0] == 3'h6) |=>
    lastTaken == ($past(flagZ) ^ $past(testField[3]))) else $error("Zero test wrong.");
  a_signed_order: assert property (s_jump_with(core_alu_pkg::SIGNED_AT_LEAST) |=>
    lastTaken == ($past(flagS) == $past(flagV))) else $error("Signed at-least test wrong.");
  a_signed_above: assert property (s_jump_with(core_alu_pkg::SIGNED_ABOVE) |=>
    lastTaken == !($past(flagZ) || ($past(flagS) != $past(flagV))))
    else $error("Signed above test wrong.");
  a_unsigned_above: assert property (s_jump_with(core_alu_pkg::UNSIGNED_ABOVE) |=>
    lastTaken == (!$past(flagC) && !$past(flagZ))) else $error("Unsigned above test wrong.");
  a_branch_target: assert property (jumpGo && !hitPc |=>
    pc == (lastTaken ? $past(target) : $past(nextSeq)))
    else $error("Program counter does not follow the test outcome.");
  a_add_sum: assert property (addGo |=>
    {flagC, dst} == ({1'b0, $past(dst)} + {1'b0, $past(src)} +
                     (DATA_W+1)'($past(carryIn)))) else $error("Sum or carry wrong.");
  a_src_kept: assert property (addGo |=> src == $past(src))
    else $error("Add changed the source operand.");
  a_zero_sign: assert property (addGo |=>
    (flagZ == (dst == '0)) && (flagS == dst[MSB])) else $error("Zero or sign flag wrong.");
  a_ovf_flag: assert property (addGo |=>
    flagV == (($past(dstMsb) == $past(srcMsb)) && (dst[MSB] != $past(dstMsb))))
    else $error("Overflow flag wrong.");
  a_half_clear: assert property (addGo |=>
    !flagD && (flagH == (dst[core_alu_pkg::HALF_BIT] ^ $past(dstBit4) ^ $past(srcBit4))))
    else $error("Half-carry or decimal flag wrong.");
  a_write_answer: assert property (s_write_taken |=> bvalid)
    else $error("Write response not raised after the write.");
  a_resp_hold: assert property (s_resp_waiting |=> bvalid)
    else $error("Write response dropped before it was taken.");

endmodule

`default_nettype wire

/* File: testbench/tb_branch_condition_and_adder.sv */
/* Self-checking bench for the jump tests and the adder, driven over AXI4-Lite.
   Assumes the register map and handshake of core_alu_pkg and the block. */
`timescale 1ns/1ps
`default_nettype none
module tb_branch_condition_and_adder;
  // ****************************************
  // Signals and the block.
  // ****************************************
  localparam int JUMP_STEP = 3;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] seed = 32'h000144a3;
  int          mismatches = 0;
  int          n_checks = 0;
  always #25 clk = ~clk;
  branch_condition_and_adder #(.DATA_W(8), .PC_W(16), .JUMP_LEN(JUMP_STEP))
    u_branch_condition_and_adder (.clk(clk), .sys_rst(sys_rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bresp(bresp), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  // ****************************************
  // Tasks and expectations.
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw;
    logic [1:0] r;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      ta = awready;
      tw = wready;
      @(posedge clk);
      if (pa && ta) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && tw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = bvalid;
      r = bresp;
      @(posedge clk);
    end while (!ta);
    bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic t;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end while (!t);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end while (!t);
    rready <= 1'b0;
    check("rresp", {30'h0, er}, {30'h0, r});
  endtask
  function automatic logic [13:0] add_exp(input logic [7:0] a, b, input logic ci);
    logic [8:0] s;
    logic [5:0] fl;
    s = {1'b0, a} + {1'b0, b} + {8'h0, ci};
    fl = 6'h00;
    fl[core_alu_pkg::FLAG_C] = s[8];
    fl[core_alu_pkg::FLAG_Z] = (s[7:0] == 8'h00);
    fl[core_alu_pkg::FLAG_S] = s[7];
    fl[core_alu_pkg::FLAG_V] = (a[7] == b[7]) && (s[7] != a[7]);
    fl[core_alu_pkg::FLAG_H] = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci}) > 5'h0f;
    return {fl, s[7:0]};
  endfunction
  function automatic logic jump_exp(input logic [3:0] t, input logic [5:0] fl);
    logic c, z, s, v, r;
    c = fl[core_alu_pkg::FLAG_C];
    z = fl[core_alu_pkg::FLAG_Z];
    s = fl[core_alu_pkg::FLAG_S];
    v = fl[core_alu_pkg::FLAG_V];
    case (t[2:0])
      3'h0: r = 1'b0;
      3'h1: r = s ^ v;
      3'h2: r = z | (s ^ v);
      3'h3: r = c | z;
      3'h4: r = v;
      3'h5: r = s;
      3'h6: r = z;
      default: r = c;
    endcase
    return r ^ t[3];
  endfunction
  // ****************************************
  // Tests.
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    logic [31:0] d;
    logic [7:0]  x, y;
    logic [7:0]  cx [4] = '{8'hff, 8'h7f, 8'h0f, 8'h80};
    logic [7:0]  cy [4] = '{8'h01, 8'h01, 8'h01, 8'h80};
    logic [5:0]  f;
    logic [13:0] e;
    logic [15:0] pc, tg;
    logic [3:0]  t;
    logic        uc, tk;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), core_alu_pkg::RESP_OKAY, d);
      check("reset value", 32'h0, d);
    end
    $display("test reset done");
    f = 6'h3f;
    wr(core_alu_pkg::OFF_FLAGS, {26'h0, f}, core_alu_pkg::RESP_OKAY);
    for (int i = 0; i < 24; i++) begin
      x = (i < 4) ? cx[i] : 8'(rnd());
      y = (i < 4) ? cy[i] : 8'(rnd());
      uc = (i < 4) ? i[0] : 1'(rnd());
      e = add_exp(x, y, uc & f[core_alu_pkg::FLAG_C]);
      wr(core_alu_pkg::OFF_DST, {24'h0, x}, core_alu_pkg::RESP_OKAY);
      wr(core_alu_pkg::OFF_SRC, {24'h0, y}, core_alu_pkg::RESP_OKAY);
      d = (32'h1 << core_alu_pkg::CMD_ADD_BIT) | (32'(uc) << core_alu_pkg::CMD_CARRY_BIT);
      wr(core_alu_pkg::OFF_CMD, d, core_alu_pkg::RESP_OKAY);
      rd(core_alu_pkg::OFF_DST, core_alu_pkg::RESP_OKAY, d);
      check("sum", {24'h0, e[7:0]}, d);
      rd(core_alu_pkg::OFF_SRC, core_alu_pkg::RESP_OKAY, d);
      check("source", {24'h0, y}, d);
      rd(core_alu_pkg::OFF_FLAGS, core_alu_pkg::RESP_OKAY, d);
      check("flags", {26'h0, e[13:8]}, d);
      f = e[13:8];
    end
    $display("test adder done");
    for (int i = 0; i < 48; i++) begin
      t = 4'(i);
      f = 6'(rnd());
      pc = 16'(rnd());
      tg = 16'(rnd());
      tk = jump_exp(t, f);
      wr(core_alu_pkg::OFF_FLAGS, {26'h0, f}, core_alu_pkg::RESP_OKAY);
      wr(core_alu_pkg::OFF_PC, {16'h0, pc}, core_alu_pkg::RESP_OKAY);
      wr(core_alu_pkg::OFF_TARGET, {16'h0, tg}, core_alu_pkg::RESP_OKAY);
      d = (32'(t) << core_alu_pkg::CMD_TEST_LSB) | (32'h1 << core_alu_pkg::CMD_JUMP_BIT);
      wr(core_alu_pkg::OFF_CMD, d, core_alu_pkg::RESP_OKAY);
      rd(core_alu_pkg::OFF_PC, core_alu_pkg::RESP_OKAY, d);
      check("pc", {16'h0, tk ? tg : pc + 16'(JUMP_STEP)}, d);
      rd(core_alu_pkg::OFF_STATUS, core_alu_pkg::RESP_OKAY, d);
      x = 8'((32'(t) << core_alu_pkg::STAT_TEST_LSB) | (32'(tk) << core_alu_pkg::STAT_TAKEN_BIT));
      check("status", {24'h0, x}, d);
    end
    $display("test jumps done");
    wr(8'h1c, 32'h0000005a, core_alu_pkg::RESP_SLVERR);
    rd(8'h1c, core_alu_pkg::RESP_SLVERR, d);
    check("unmapped read", 32'h0, d);
    wr(core_alu_pkg::OFF_STATUS, 32'h000000ff, core_alu_pkg::RESP_OKAY);
    rd(core_alu_pkg::OFF_STATUS, core_alu_pkg::RESP_OKAY, d);
    check("status kept", {24'h0, x}, d);
    rd(core_alu_pkg::OFF_CMD, core_alu_pkg::RESP_OKAY, d);
    check("command read", 32'h0, d);
    wstrb <= 4'he;
    wr(core_alu_pkg::OFF_DST, 32'h000000a5, core_alu_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    rd(core_alu_pkg::OFF_DST, core_alu_pkg::RESP_OKAY, d);
    check("lane kept", {24'h0, e[7:0]}, d);
    $display("test bus answers done");
    end_of_test();
  end
endmodule
`default_nettype wire
